// File: rtl/sbof_formatter.sv
`timescale 1ns/1ps
module sbof_formatter
   import sbof_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire sbof_cfg_t cfg,
   input wire logic start,
   input wire logic go_idle,
   input wire logic smp_valid,
   input wire logic [31:0] smp_re,
   input wire logic [31:0] smp_im,
   input wire logic adc_ovld,
   input wire logic adc_err,
   input wire logic sampler_tick_onboard,
   input wire logic sampler_tick_ttl,
   input wire logic sampler_tick_shared,
   input wire logic align_local,
   input wire logic align_shared,
   input wire logic proc_tick_onboard,
   input wire logic fifo_space,
   output logic smp_ready,
   output logic sampler_tick,
   output logic proc_tick,
   output logic align_pulse,
   output logic capturing,
   output logic overflow,
   output logic [4:0] len_log2,
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data,
   output logic out_last,
   output logic out_trailer,
   output logic out_port
);
   typedef enum logic [1:0] {SB_IDLE, SB_RUN, SB_IMAG, SB_TRAIL} sbof_st_t;
   typedef struct packed {
      sbof_st_t st;
      logic [31:0] cnt;
      logic ovld;
      logic err;
      logic ovf;
      logic [4:0] l2;
      logic [31:0] im_hold;
      logic sclk;
      logic pclk;
      logic algn;
      sbof_word_t [1:0] buf_w;
      logic [1:0] buf_n;
      logic rd;
      logic wr;
      logic cap;
      logic vld;
   } sbof_state_t;
   sbof_state_t s_r, s_nxt;

   logic [4:0] req_l2, min_l2, cap_l2, use_l2;
   logic [31:0] blk_len;
   logic push, pop, buf_full;
   sbof_word_t push_w;
   logic blk_end;

   always_comb begin
      req_l2 = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (cfg.req_len[i]) begin
            req_l2 = 5'(i);
         end
      end
      unique case ({cfg.is_complex, cfg.is_wide})
         2'b00: begin
            min_l2 = MIN_R16_LOG2;
            cap_l2 = LEN_MAX_LOG2 - BPS_R16_LOG2;
         end
         2'b01: begin
            min_l2 = MIN_R32_LOG2;
            cap_l2 = LEN_MAX_LOG2 - BPS_R32_LOG2;
         end
         2'b10: begin
            min_l2 = MIN_C16_LOG2;
            cap_l2 = LEN_MAX_LOG2 - BPS_C16_LOG2;
         end
         default: begin
            min_l2 = MIN_C32_LOG2;
            cap_l2 = LEN_MAX_LOG2 - BPS_C32_LOG2;
         end
      endcase
      use_l2 = req_l2;
      if (use_l2 < min_l2) begin
         use_l2 = min_l2;
      end
      if (use_l2 > cap_l2) begin
         use_l2 = cap_l2;
      end
   end

   assign blk_len = 32'h00000001 << s_r.l2;
   assign buf_full = s_r.buf_n == 2'h2;
   assign pop = out_ready && s_r.buf_n != 2'h0;

   function automatic logic [31:0] fmt(input logic [31:0] v, input logic wide);
      fmt = wide ? v : {16'h0000, v[31:16]};
   endfunction

   always_comb begin
      s_nxt = s_r;
      push = 1'b0;
      push_w = '0;
      blk_end = s_r.cnt == blk_len - 32'h00000001;
      s_nxt.sclk = cfg.shared_timing ? sampler_tick_shared :
         (cfg.sclk_sel == SBOF_SRC_TTL ? sampler_tick_ttl : sampler_tick_onboard);
      // selection changes pacing only, never the data path
      s_nxt.pclk = cfg.pclk_sel == SBOF_PROC_ONBOARD ? proc_tick_onboard : s_r.sclk;
      s_nxt.algn = cfg.shared_timing ? align_shared : align_local;
      s_nxt.rd = 1'b0;
      s_nxt.wr = cfg.port_sel == SBOF_PORT_LOCAL;
      if (pop) begin
         s_nxt.buf_w[0] = s_r.buf_w[1];
         s_nxt.buf_n = s_r.buf_n - 2'h1;
      end
      unique case (s_r.st)
         SB_IDLE: begin
            if (start) begin
               s_nxt.st = SB_RUN;
               s_nxt.cnt = '0;
               s_nxt.ovld = 1'b0;
               s_nxt.err = 1'b0;
               s_nxt.ovf = 1'b0;
               s_nxt.l2 = use_l2;
            end
         end
         SB_RUN: begin
            s_nxt.ovld = s_r.ovld | adc_ovld;
            s_nxt.err = s_r.err | adc_err;
            if (smp_valid && !buf_full) begin
               if (!fifo_space) begin
                  s_nxt.ovf = 1'b1;
                  s_nxt.st = SB_IDLE;
               end else begin
                  push = 1'b1;
                  push_w.data = fmt(smp_re, cfg.is_wide);
                  if (cfg.is_complex) begin
                     s_nxt.im_hold = smp_im;
                     s_nxt.st = SB_IMAG;
                  end else begin
                     push_w.last = blk_end && !cfg.trailer_en;
                     s_nxt.cnt = blk_end ? '0 : s_r.cnt + 32'h00000001;
                     if (blk_end) begin
                        s_nxt.st = cfg.trailer_en ? SB_TRAIL : (cfg.free_run ? SB_RUN : SB_IDLE);
                     end
                  end
               end
            end
            if (go_idle) begin
               s_nxt.st = SB_IDLE;
            end
         end
         SB_IMAG: begin
            s_nxt.ovld = s_r.ovld | adc_ovld;
            s_nxt.err = s_r.err | adc_err;
            if (!buf_full) begin
               push = 1'b1;
               push_w.data = fmt(s_r.im_hold, cfg.is_wide);
               push_w.last = blk_end && !cfg.trailer_en;
               s_nxt.cnt = blk_end ? '0 : s_r.cnt + 32'h00000001;
               s_nxt.st = SB_RUN;
               if (blk_end) begin
                  s_nxt.st = cfg.trailer_en ? SB_TRAIL : (cfg.free_run ? SB_RUN : SB_IDLE);
               end
            end
         end
         SB_TRAIL: begin
            if (!buf_full) begin
               push = 1'b1;
               push_w.data = '0; // low byte only
               push_w.data[TRL_OVLD_BIT] = s_r.ovld | adc_ovld;
               push_w.data[TRL_ERR_BIT] = s_r.err | adc_err;
               push_w.last = 1'b1;
               push_w.trailer = 1'b1;
               s_nxt.ovld = 1'b0;
               s_nxt.err = 1'b0;
               s_nxt.st = cfg.free_run ? SB_RUN : SB_IDLE;
            end
         end
         default: s_nxt.st = SB_IDLE;
      endcase
      if (push) begin
         s_nxt.buf_w[pop ? s_r.buf_n - 2'h1 : s_r.buf_n] = push_w;
         s_nxt.buf_n = pop ? s_r.buf_n : s_r.buf_n + 2'h1;
      end
      s_nxt.rd = s_nxt.st == SB_RUN && s_nxt.buf_n != 2'h2;
      s_nxt.cap = s_nxt.st != SB_IDLE;
      s_nxt.vld = s_nxt.buf_n != 2'h0;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign smp_ready = s_r.rd;
   assign sampler_tick = s_r.sclk;
   assign proc_tick = s_r.pclk;
   assign align_pulse = s_r.algn;
   assign capturing = s_r.cap;
   assign overflow = s_r.ovf;
   assign len_log2 = s_r.l2;
   assign out_valid = s_r.vld;
   assign out_data = s_r.buf_w[0].data;
   assign out_last = s_r.buf_w[0].last;
   assign out_trailer = s_r.buf_w[0].trailer;
   assign out_port = s_r.wr;

   AST_BUF_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_r.buf_n <= 2'h2) else $error("buffer count above two");
   AST_TRL_LAST: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_valid && out_trailer |-> out_last) else $error("trailer not last");
   AST_TRL_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_valid && out_trailer |-> out_data[31:8] == 24'h000000) else $error("trailer wide");
   AST_LEN_MIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      capturing && !cfg.is_wide && !cfg.is_complex && clk_en && $stable(cfg)
      |-> len_log2 >= MIN_R16_LOG2 || $past(start) == 1'b0) else $error("length below minimum");
   AST_OVF_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(overflow) |-> !capturing) else $error("overflow kept capturing");
   AST_SCLK_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && cfg.shared_timing |=> !clk_en || sampler_tick == $past(sampler_tick_shared))
      else $error("shared sampler clock not used");
   AST_ALIGN_LOCAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !cfg.shared_timing |=> !clk_en || align_pulse == $past(align_local))
      else $error("local alignment not used");
   AST_HOLD_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_valid && !out_ready && clk_en |=> out_valid && $stable(out_data))
      else $error("word lost under stall");

   // handshake and control events watched by the checks below
   sequence s_take;
      smp_valid && smp_ready && clk_en && fifo_space;
   endsequence

   sequence s_refuse;
      smp_valid && smp_ready && clk_en && !fifo_space;
   endsequence

   sequence s_start;
      start && !capturing && clk_en;
   endsequence

   sequence s_trl_push;
      s_r.st == SB_TRAIL && !buf_full && clk_en;
   endsequence

   sequence s_run_stop;
      go_idle && s_r.st == SB_RUN && clk_en;
   endsequence

   AST_TAKE_WORD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_take |=> out_valid) else $error("taken sample gave no word");

   AST_CPLX_IMAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_take ##0 cfg.is_complex |=> !smp_ready) else $error("imaginary slot not reserved");

   AST_NARROW_FMT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_valid && !out_trailer && !cfg.is_wide |-> out_data[31:16] == 16'h0000)
      else $error("narrow word too wide");

   AST_START_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_start |=> capturing && !overflow && len_log2 == $past(use_l2))
      else $error("block length not latched at start");

   AST_OVF_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_refuse |=> overflow && !capturing) else $error("overflow not flagged");

   AST_IDLE_CMD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_run_stop |=> !capturing && !smp_ready) else $error("idle command ignored");

   AST_BLOCK_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_trl_push ##0 !cfg.free_run |=> !capturing) else $error("single block kept running");

   AST_STICKY_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_trl_push |=> !s_r.ovld && !s_r.err) else $error("block flags not cleared");

   AST_TRL_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_valid && out_trailer |-> cfg.trailer_en) else $error("trailer while disabled");

   AST_PORT_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en |=> !clk_en || out_port == ($past(cfg.port_sel) == SBOF_PORT_LOCAL))
      else $error("output path not selected");

   AST_PCLK_ONB: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && cfg.pclk_sel == SBOF_PROC_ONBOARD |=> !clk_en || proc_tick == $past(proc_tick_onboard))
      else $error("processing clock not onboard");

   AST_SCLK_TTL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !cfg.shared_timing && cfg.sclk_sel == SBOF_SRC_TTL
      |=> !clk_en || sampler_tick == $past(sampler_tick_ttl))
      else $error("ttl sampler clock not used");

   AST_SCLK_LOCAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !cfg.shared_timing && cfg.sclk_sel == SBOF_SRC_ONBOARD
      |=> !clk_en || sampler_tick == $past(sampler_tick_onboard))
      else $error("onboard sampler clock not used");

   AST_ALIGN_SHARED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && cfg.shared_timing |=> !clk_en || align_pulse == $past(align_shared))
      else $error("shared alignment not used");

   AST_READY_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      smp_ready |-> capturing) else $error("ready while idle");
endmodule

// File: rtl/sbof_pkg.sv
package sbof_pkg;
   localparam int FIFO_BYTES_LOG2 = 12;
   localparam logic [4:0] LEN_MAX_LOG2 = 5'(FIFO_BYTES_LOG2);
   localparam logic [4:0] MIN_R16_LOG2 = 5'h02;
   localparam logic [4:0] MIN_R32_LOG2 = 5'h01;
   localparam logic [4:0] MIN_C16_LOG2 = 5'h01;
   localparam logic [4:0] MIN_C32_LOG2 = 5'h00;
   localparam logic [4:0] BPS_R16_LOG2 = 5'h01;
   localparam logic [4:0] BPS_R32_LOG2 = 5'h02;
   localparam logic [4:0] BPS_C16_LOG2 = 5'h02;
   localparam logic [4:0] BPS_C32_LOG2 = 5'h03;
   localparam int TRL_OVLD_BIT = 0;
   localparam int TRL_ERR_BIT = 1;
   localparam logic [31:0] FIFO_WORDS = 32'h00000400;
   typedef enum logic {SBOF_SRC_ONBOARD, SBOF_SRC_TTL} sbof_sclk_t;
   typedef enum logic {SBOF_PROC_SAMPLER, SBOF_PROC_ONBOARD} sbof_pclk_t;
   typedef enum logic {SBOF_PORT_BACKPLANE, SBOF_PORT_LOCAL} sbof_port_t;
   typedef struct packed {
      logic is_complex;
      logic is_wide;
      logic free_run;
      logic trailer_en;
      logic shared_timing;
      sbof_sclk_t sclk_sel;
      sbof_pclk_t pclk_sel;
      sbof_port_t port_sel;
      logic [31:0] req_len;
   } sbof_cfg_t;
   typedef struct packed {
      logic [31:0] data;
      logic last;
      logic trailer;
   } sbof_word_t;
endpackage

// File: test/sbof_host_model.sv
`timescale 1ns/1ps
module sbof_host_model
   import sbof_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic out_valid,
   input wire logic [31:0] out_data,
   input wire logic out_last,
   input wire logic out_trailer,
   output logic out_ready
);
   sbof_word_t q[$];
   logic [1:0] cnt_r;
   // reader stalls two cycles of four when asked, takes each word alone
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         out_ready <= !stall || cnt_r[1];
         if (out_valid && out_ready) begin
            q.push_back('{out_data, out_last, out_trailer});
         end
      end
   end
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import sbof_pkg::*;
;
   logic ref_clk = 0, rst_n = 0, clk_en, start, go_idle, smp_valid, adc_ovld, adc_err;
   logic fifo_space, stall, st_on, st_ttl, st_sh, al_loc, al_sh, pt_on, e;
   logic smp_ready, sampler_tick, proc_tick, align_pulse, capturing, overflow;
   logic out_valid, out_ready, out_last, out_trailer, out_port;
   logic [31:0] smp_re, smp_im, out_data;
   logic [4:0] len_log2;
   sbof_cfg_t cfg;
   int error_cnt = 0, compares = 0, i;
   always #4 ref_clk = ~ref_clk;
   sbof_formatter u_sbof_formatter (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .cfg(cfg), .start(start), .go_idle(go_idle), .smp_valid(smp_valid), .smp_re(smp_re),
      .smp_im(smp_im), .adc_ovld(adc_ovld), .adc_err(adc_err), .sampler_tick_onboard(st_on),
      .sampler_tick_ttl(st_ttl), .sampler_tick_shared(st_sh), .align_local(al_loc),
      .align_shared(al_sh), .proc_tick_onboard(pt_on), .fifo_space(fifo_space),
      .smp_ready(smp_ready), .sampler_tick(sampler_tick), .proc_tick(proc_tick),
      .align_pulse(align_pulse), .capturing(capturing), .overflow(overflow),
      .len_log2(len_log2), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .out_last(out_last), .out_trailer(out_trailer), .out_port(out_port));
   sbof_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
      .out_trailer(out_trailer), .out_ready(out_ready));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask
   task automatic final_report();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic go(input sbof_cfg_t c);
      cfg <= c;
      cyc(1);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(1);
   endtask
   task automatic idle();
      go_idle <= 1'b1;
      cyc(1);
      go_idle <= 1'b0;
      cyc(3);
      chkb(capturing, 1'b0, "idle");
      u_host.q.delete();
   endtask
   task automatic send(input logic [31:0] re, input logic [31:0] im);
      int n;
      n = 0;
      smp_re <= re;
      smp_im <= im;
      smp_valid <= 1'b1;
      cyc(1);
      while (smp_ready !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      smp_valid <= 1'b0;
      cyc(1);
      if (n >= 200) begin
         error_cnt++;
         $display("mismatch at %0t: sample never taken", $time);
      end
   endtask
   // f: complex, wide, trailer, local port with onboard processing clock
   task automatic blk(input logic [3:0] f, input logic [31:0] len, input logic [4:0] lg,
                      input int n, input logic [1:0] flg);
      sbof_word_t w;
      int nw;
      int k;
      nw = n * (f[3] ? 2 : 1) + (f[1] ? 1 : 0);
      go('{f[3], f[2], 1'b0, f[1], 1'b0, SBOF_SRC_ONBOARD, sbof_pclk_t'(f[0]),
           sbof_port_t'(f[0]), len});
      chk({27'h0, len_log2}, {27'h0, lg}, "len");
      chkb(out_port, f[0], "port");
      adc_ovld <= flg[0];
      adc_err <= flg[1];
      for (k = 0; k < n; k++) begin
         send(32'hC0000000 | k, 32'h30000000 | k);
      end
      adc_ovld <= 1'b0;
      adc_err <= 1'b0;
      k = 0;
      while (u_host.q.size() < nw && k < 500) begin
         cyc(1);
         k++;
      end
      cyc(3);
      chkb(capturing, 1'b0, "stop");
      chk(u_host.q.size(), nw, "count");
      for (k = 0; k < nw; k++) begin
         w = u_host.q.pop_front();
         chkb(w.last, k == nw - 1, "last");
         chkb(w.trailer, f[1] && k == nw - 1, "trl");
         if (f[1] && k == nw - 1) begin
            chk({30'h0, w.data[1:0]}, {30'h0, flg}, "flags");
         end else if (f[2]) begin
            chk(w.data, (f[3] && k[0]) ? 32'h30000000 | k / 2 :
               32'hC0000000 | (k >> f[3]), "data");
         end else begin
            chk(w.data, (f[3] && k[0]) ? 32'h00003000 : 32'h0000C000, "narrow");
         end
      end
      $display("test block %h done", f);
   endtask
   initial begin
      {clk_en, start, go_idle, smp_valid, adc_ovld, adc_err} = 6'h20;
      {fifo_space, stall, st_on, st_ttl, st_sh, al_loc, al_sh, pt_on} = 8'hC0;
      {smp_re, smp_im} = '0;
      cfg = '0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(1);
      blk(4'h2, 32'h5, 5'h02, 4, 2'h1);
      blk(4'hF, 32'h0, 5'h00, 1, 2'h2);
      blk(4'h4, 32'h3, 5'h01, 2, 2'h0);
      blk(4'hA, 32'h2, 5'h01, 2, 2'h0);
      for (i = 0; i < 3; i++) begin
         go('{i[1], i[0] | i[1], 1'b0, 1'b0, 1'b0, SBOF_SRC_ONBOARD, SBOF_PROC_SAMPLER,
              SBOF_PORT_BACKPLANE, 32'hFFFFFFFF});
         chk({27'h0, len_log2}, 32'd11 - i, "clip");
         idle();
      end
      $display("test clip done");
      go('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, SBOF_SRC_ONBOARD, SBOF_PROC_SAMPLER,
           SBOF_PORT_BACKPLANE, 32'h1});
      for (i = 0; i < 3; i++) begin
         send(i, i);
      end
      cyc(2);
      chkb(capturing, 1'b1, "run");
      idle();
      go(cfg);
      fifo_space <= 1'b0;
      send(32'h1, 32'h2);
      cyc(2);
      chkb(overflow, 1'b1, "ovf");
      chkb(capturing, 1'b0, "ovfidle");
      fifo_space <= 1'b1;
      u_host.q.delete();
      $display("test free run done");
      for (i = 0; i < 32; i++) begin
         cfg.shared_timing <= i[4];
         cfg.sclk_sel <= sbof_sclk_t'(i[3]);
         cfg.pclk_sel <= sbof_pclk_t'(i[1]);
         {st_on, st_ttl, st_sh, al_loc, al_sh, pt_on} <= {i[0], i[1], i[2], i[1], i[0], !i[0]};
         cyc(4);
         e = i[4] ? i[2] : (i[3] ? i[1] : i[0]);
         chkb(sampler_tick, e, "sclk");
         chkb(proc_tick, i[1] ? !i[0] : e, "pclk");
         chkb(align_pulse, i[4] ? i[0] : i[1], "align");
      end
      $display("test clocks done");
      final_report();
   end
   initial begin
      cyc(30000);
      error_cnt++;
      $display("mismatch at %0t: watchdog", $time);
      final_report();
   end
endmodule
